/* logic/rtctd_bcd_check.sv */
// Purpose: check that a bcd value holds valid digits within a range
// Assumes: width 7 or less, tens in upper bits
// Notes: pure combinational
module rtctd_bcd_check #(
  parameter int W = 7
) (
  input wire logic [W-1:0] value,
  input wire logic [W-1:0] lo,
  input wire logic [W-1:0] hi,
  output logic ok
);
  // units above 9 would slip past a plain compare
  assign ok = (value[3:0] <= 4'h9) && (value >= lo) && (value <= hi);
endmodule

/* logic/rtctd_pkg.sv */
// Purpose: constants for the clock time and interrupt disable block
// Assumes: apb with 32-bit data, word-aligned registers
// Notes: offsets are local choices
package rtctd_pkg;
  localparam logic [7:0] rtctd_off_time = 8'h00;
  localparam logic [7:0] rtctd_off_ier = 8'h04;
  localparam logic [7:0] rtctd_off_idr = 8'h08;
  localparam logic [7:0] rtctd_off_imr = 8'h0c;
  localparam logic [7:0] rtctd_off_mode = 8'h10;
  localparam logic [7:0] rtctd_off_sr = 8'h14;
  localparam logic [7:0] rtctd_off_sie = 8'h18;
  localparam int rtctd_ss_lsb = 0;
  localparam int rtctd_mm_lsb = 8;
  localparam int rtctd_hh_lsb = 16;
  localparam int rtctd_mer_bit = 22;
  localparam int rtctd_nsrc = 5;
  localparam int rtctd_src_ack = 0;
  localparam int rtctd_src_alarm = 1;
  localparam int rtctd_src_tick = 2;
  localparam int rtctd_src_time = 3;
  localparam int rtctd_src_date = 4;
  localparam logic [6:0] rtctd_ss_max = 7'h59;
  localparam logic [6:0] rtctd_mm_max = 7'h59;
  localparam logic [5:0] rtctd_hh12_min = 6'h01;
  localparam logic [5:0] rtctd_hh12_max = 6'h12;
  localparam logic [5:0] rtctd_hh24_max = 6'h23;
  localparam logic [6:0] rtctd_ss_rst = 7'h00;
  localparam logic [6:0] rtctd_mm_rst = 7'h00;
  localparam logic [5:0] rtctd_hh_rst = 6'h00;
  localparam logic [4:0] rtctd_mask_rst = 5'h00;
endpackage

/* logic/rtctd_top.sv */
// Purpose: time-of-day register and interrupt disable logic of a real-time clock
// Assumes: apb slave on pclk, zero wait states
// Notes: event inputs come from the counting chain on the same clock
// Operation
// - seconds and minutes held in bcd, writes accepted only within 0-59
// - units digit in low four bits, tens digit above, for ss and mm
// - hours in bcd, writes accepted only within 1-12 in 12-hour mode, 0-23 in 24-hour mode
// - meridiem flag at bit 22 in 12-hour mode, 0 morning, 1 afternoon
// - undefined bits of the time register read as zero
// - disable bit 0 masks update acknowledge; writing 0 does nothing
// - disable bit 1 masks the alarm source
// - disable bit 2 masks the once-per-second tick
// - disable bit 3 masks the time event source
// - disable bit 4 masks the calendar event source
module rtctd_top (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [4:0] event_in,
  input wire logic tick_en,
  output logic mode_12h,
  output logic [4:0] irq_enabled,
  output logic irq
);
  logic [6:0] ss_q;
  logic [6:0] mm_q;
  logic [5:0] hh_q;
  logic mer_q;
  logic mode_q;
  logic [4:0] imr_q;
  logic [4:0] sr_q;
  logic [4:0] sie_q;
  logic wr;
  logic rd;
  logic ss_ok;
  logic mm_ok;
  logic hh_ok;
  logic [6:0] w_ss;
  logic [6:0] w_mm;
  logic [5:0] w_hh;
  logic [5:0] hh_lo;
  logic [5:0] hh_hi;
  logic time_wr_ok;
  logic mapped;
  logic [31:0] rdata_d;

  assign wr = psel && penable && pwrite;
  assign rd = psel && penable && !pwrite;
  assign pready = 1'b1;

  always_comb begin
    case (paddr)
      rtctd_pkg::rtctd_off_time, rtctd_pkg::rtctd_off_ier, rtctd_pkg::rtctd_off_idr,
      rtctd_pkg::rtctd_off_imr, rtctd_pkg::rtctd_off_mode, rtctd_pkg::rtctd_off_sr,
      rtctd_pkg::rtctd_off_sie: mapped = 1'b1;
      default: mapped = 1'b0;
    endcase
  end
  // out-of-range time writes are refused with an error, not clipped
  assign pslverr = psel && penable && (!mapped ||
    (pwrite && paddr == rtctd_pkg::rtctd_off_time && !time_wr_ok));

  // field extraction
  assign w_ss = pwdata[rtctd_pkg::rtctd_ss_lsb +: 7];
  assign w_mm = pwdata[rtctd_pkg::rtctd_mm_lsb +: 7];
  assign w_hh = pwdata[rtctd_pkg::rtctd_hh_lsb +: 6];
  assign hh_lo = mode_q ? rtctd_pkg::rtctd_hh12_min : 6'h00;
  assign hh_hi = mode_q ? rtctd_pkg::rtctd_hh12_max : rtctd_pkg::rtctd_hh24_max;

  rtctd_bcd_check #(.W(7)) u_ss_chk (
    .value(w_ss),
    .lo(7'h00),
    .hi(rtctd_pkg::rtctd_ss_max),
    .ok(ss_ok)
  );
  rtctd_bcd_check #(.W(7)) u_mm_chk (
    .value(w_mm),
    .lo(7'h00),
    .hi(rtctd_pkg::rtctd_mm_max),
    .ok(mm_ok)
  );
  rtctd_bcd_check #(.W(6)) u_hh_chk (
    .value(w_hh),
    .lo(hh_lo),
    .hi(hh_hi),
    .ok(hh_ok)
  );
  assign time_wr_ok = ss_ok && mm_ok && hh_ok;

  // time-of-day; the one-second tick advances it in bcd
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ss_q <= rtctd_pkg::rtctd_ss_rst;
      mm_q <= rtctd_pkg::rtctd_mm_rst;
      hh_q <= rtctd_pkg::rtctd_hh_rst;
      mer_q <= 1'b0;
    end else if (wr && paddr == rtctd_pkg::rtctd_off_time && time_wr_ok) begin
      ss_q <= w_ss;
      mm_q <= w_mm;
      hh_q <= w_hh;
      mer_q <= mode_q ? pwdata[rtctd_pkg::rtctd_mer_bit] : 1'b0;
    end else if (tick_en) begin
      if (ss_q != rtctd_pkg::rtctd_ss_max) begin
        ss_q <= (ss_q[3:0] == 4'h9) ? {ss_q[6:4] + 3'h1, 4'h0} : ss_q + 7'h01;
      end else begin
        ss_q <= 7'h00;
        if (mm_q != rtctd_pkg::rtctd_mm_max) begin
          mm_q <= (mm_q[3:0] == 4'h9) ? {mm_q[6:4] + 3'h1, 4'h0} : mm_q + 7'h01;
        end else begin
          mm_q <= 7'h00;
          if (mode_q) begin
            // 12-hour wrap: 11 -> 12 flips meridiem, 12 -> 01
            if (hh_q == rtctd_pkg::rtctd_hh12_max) begin
              hh_q <= rtctd_pkg::rtctd_hh12_min;
            end else begin
              hh_q <= (hh_q[3:0] == 4'h9) ? {hh_q[5:4] + 2'h1, 4'h0} : hh_q + 6'h01;
              if (hh_q == 6'h11) begin
                mer_q <= ~mer_q;
              end
            end
          end else if (hh_q == rtctd_pkg::rtctd_hh24_max) begin
            hh_q <= 6'h00;
          end else begin
            hh_q <= (hh_q[3:0] == 4'h9) ? {hh_q[5:4] + 2'h1, 4'h0} : hh_q + 6'h01;
          end
        end
      end
    end
  end

  // hour mode; changing it does not convert the stored hour
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mode_q <= 1'b0;
    end else if (wr && paddr == rtctd_pkg::rtctd_off_mode) begin
      mode_q <= pwdata[0];
    end
  end

  // interrupt mask: enable sets, disable clears, zeros do nothing
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      imr_q <= rtctd_pkg::rtctd_mask_rst;
    end else if (wr && paddr == rtctd_pkg::rtctd_off_ier) begin
      imr_q <= imr_q | pwdata[rtctd_pkg::rtctd_nsrc-1:0];
    end else if (wr && paddr == rtctd_pkg::rtctd_off_idr) begin
      imr_q[rtctd_pkg::rtctd_src_ack] <= imr_q[rtctd_pkg::rtctd_src_ack] &
        ~pwdata[rtctd_pkg::rtctd_src_ack];
      imr_q[rtctd_pkg::rtctd_src_alarm] <= imr_q[rtctd_pkg::rtctd_src_alarm] &
        ~pwdata[rtctd_pkg::rtctd_src_alarm];
      imr_q[rtctd_pkg::rtctd_src_tick] <= imr_q[rtctd_pkg::rtctd_src_tick] &
        ~pwdata[rtctd_pkg::rtctd_src_tick];
      imr_q[rtctd_pkg::rtctd_src_time] <= imr_q[rtctd_pkg::rtctd_src_time] &
        ~pwdata[rtctd_pkg::rtctd_src_time];
      imr_q[rtctd_pkg::rtctd_src_date] <= imr_q[rtctd_pkg::rtctd_src_date] &
        ~pwdata[rtctd_pkg::rtctd_src_date];
    end
  end

  // sticky events, cleared by reading; a new event in the read cycle survives
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sr_q <= 5'h00;
    end else if (rd && paddr == rtctd_pkg::rtctd_off_sr) begin
      sr_q <= event_in;
    end else begin
      sr_q <= sr_q | event_in;
    end
  end

  // status interrupt mask, same layout as the status register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sie_q <= rtctd_pkg::rtctd_mask_rst;
    end else if (wr && paddr == rtctd_pkg::rtctd_off_sie) begin
      sie_q <= pwdata[rtctd_pkg::rtctd_nsrc-1:0];
    end
  end

  // a source raises irq only if enabled in both masks
  assign irq = |(sr_q & sie_q & imr_q);
  assign mode_12h = mode_q;
  assign irq_enabled = imr_q;

  always_comb begin
    rdata_d = 32'h0000_0000;
    case (paddr)
      rtctd_pkg::rtctd_off_time: begin
        rdata_d[rtctd_pkg::rtctd_ss_lsb +: 7] = ss_q;
        rdata_d[rtctd_pkg::rtctd_mm_lsb +: 7] = mm_q;
        rdata_d[rtctd_pkg::rtctd_hh_lsb +: 6] = hh_q;
        rdata_d[rtctd_pkg::rtctd_mer_bit] = mer_q;
      end
      rtctd_pkg::rtctd_off_idr: rdata_d = 32'h0000_0000;
      rtctd_pkg::rtctd_off_imr: rdata_d[rtctd_pkg::rtctd_nsrc-1:0] = imr_q;
      rtctd_pkg::rtctd_off_mode: rdata_d[0] = mode_q;
      rtctd_pkg::rtctd_off_sr: rdata_d[rtctd_pkg::rtctd_nsrc-1:0] = sr_q;
      rtctd_pkg::rtctd_off_sie: rdata_d[rtctd_pkg::rtctd_nsrc-1:0] = sie_q;
      default: rdata_d = 32'h0000_0000;
    endcase
  end

  // read data registered in the setup cycle, valid in the access cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
    end else if (psel && !penable && !pwrite) begin
      prdata <= rdata_d;
    end
  end
endmodule

/* verif/rtctd_chk_asserts.sv */
// Purpose: port checker for the clock time and irq disable block
// Assumes: zero wait state apb on pclk
// Notes: hour range checked in 24-hour mode only, mode change keeps hour
module rtctd_chk_asserts (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic [4:0] event_in,
  input wire logic tick_en,
  input wire logic mode_12h,
  input wire logic [4:0] irq_enabled,
  input wire logic irq
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  wire wr = psel && penable && pwrite;
  wire rdt = psel && penable && !pwrite && paddr == 8'h00;
  a_idr_clears: assert property (wr && paddr == 8'h08
    |=> irq_enabled == ($past(irq_enabled) & ~$past(pwdata[4:0]))) else $error("idr write");
  a_no_reenable: assert property (!(wr && paddr == 8'h04)
    |=> (irq_enabled & ~$past(irq_enabled)) == 5'h00) else $error("mask set");
  a_idr_reads_zero: assert property (psel && penable && !pwrite && paddr == 8'h08
    |-> prdata == 32'h0) else $error("idr read");
  a_time_rsvd: assert property (rdt |-> (prdata & 32'hff80_8080) == 32'h0)
    else $error("time reserved bits");
  a_ss_bcd: assert property (rdt |-> prdata[3:0] <= 4'h9 && prdata[6:0] <= 7'h59)
    else $error("seconds bcd");
  a_mm_bcd: assert property (rdt |-> prdata[11:8] <= 4'h9 && prdata[14:8] <= 7'h59)
    else $error("minutes bcd");
  a_hh_24h: assert property (rdt && !mode_12h
    |-> prdata[19:16] <= 4'h9 && prdata[21:16] <= 6'h23) else $error("hours bcd");
  a_bad_ss_err: assert property (wr && paddr == 8'h00 && pwdata[3:0] > 4'h9
    |-> pslverr) else $error("bad seconds taken");
  a_hh12_zero_err: assert property (wr && paddr == 8'h00 && mode_12h
    && pwdata[21:16] == 6'h00 |-> pslverr) else $error("hour zero taken");
  c_irq: cover property (irq);
  c_err: cover property (psel && penable && pslverr);
  c_idr: cover property (wr && paddr == 8'h08);
endmodule

bind rtctd_top rtctd_chk_asserts u_chk (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .event_in(event_in), .tick_en(tick_en),
  .mode_12h(mode_12h), .irq_enabled(irq_enabled), .irq(irq));

/* verif/tb_top.sv */
// Purpose: self-checking bench for the clock time and irq disable block
// Assumes: zero wait state apb, event pulses on pclk
// Notes: a status read clears it, so it is read once per case
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, tick_en = 0, er;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic [31:0] bad [4] = '{32'h0001_005a, 32'h0001_6000, 32'h0013_0000, 32'h0};
  logic pready, pslverr, mode_12h, irq;
  logic [4:0] event_in = 5'h00, irq_enabled;
  int errors = 0, comparisons = 0, cycles = 0;
  rtctd_top uut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .event_in(event_in), .tick_en(tick_en), .mode_12h(mode_12h),
    .irq_enabled(irq_enabled), .irq(irq));
  always #50 pclk = ~pclk;
  task end_sim();
    $display("errors %0d comparisons %0d", errors, comparisons);
    if (errors == 0 && comparisons > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  // the ceiling is well above the hundred or so cycles the tests need
  always @(posedge pclk) begin
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      errors = errors + 1;
      end_sim();
    end
  end
  task chk(input string n, input logic [31:0] e, input logic [31:0] g);
    comparisons++;
    if (g !== e) begin
      errors++;
      $display("[ERR] %s expected %h seen %h", n, e, g);
    end
  endtask
  // #1 lets the edge's updates land before any flag is looked at
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    #1;
  endtask
  task pulse(input logic [4:0] ev, input logic tk);
    @(posedge pclk);
    event_in <= ev;
    tick_en <= tk;
    @(posedge pclk);
    event_in <= 5'h00;
    tick_en <= 1'b0;
    #1;
  endtask
  task t_reset();
    apb(0, 8'h00, 0);
    chk("time", 32'h0, rd);
    chk("irq_enabled", 32'h0, {27'h0, irq_enabled});
    apb(0, 8'h08, 0);
    chk("idr read", 32'h0, rd);
    apb(0, 8'h40, 0);
    chk("unmapped err", 32'h1, {31'h0, er});
    chk("pready", 32'h1, {31'h0, pready});
    chk("mode reset", 32'h0, {31'h0, mode_12h});
    $display("test reset done");
  endtask
  task t_time();
    apb(1, 8'h10, 32'h1);
    apb(1, 8'h00, 32'h0052_3459);
    chk("mode 12h", 32'h1, {31'h0, mode_12h});
    chk("pm write err", 32'h0, {31'h0, er});
    apb(0, 8'h00, 0);
    chk("time 12h", 32'h0052_3459, rd);
    for (int i = 0; i < 4; i++) begin
      apb(1, 8'h00, bad[i]);
      chk("bad time err", 32'h1, {31'h0, er});
      apb(0, 8'h00, 0);
      chk("time kept", 32'h0052_3459, rd);
    end
    apb(1, 8'h10, 32'h0);
    apb(1, 8'h00, 32'h0063_5959);
    chk("mode 24h", 32'h0, {31'h0, mode_12h});
    apb(0, 8'h00, 0);
    chk("time 24h", 32'h0023_5959, rd);
    pulse(5'h00, 1'b1);
    apb(0, 8'h00, 0);
    chk("time wrap", 32'h0, rd);
    $display("test time done");
  endtask
  task t_idr();
    apb(1, 8'h04, 32'h1f);
    apb(1, 8'h08, 32'h0);
    chk("idr zero", 32'h1f, {27'h0, irq_enabled});
    for (int i = 0; i < 5; i++) begin
      apb(1, 8'h08, 32'h1 << i);
      chk("idr bit", 32'h1f & ~((32'h2 << i) - 1), {27'h0, irq_enabled});
    end
    $display("test idr done");
  endtask
  task t_irq();
    apb(1, 8'h18, 32'h1f);
    apb(1, 8'h04, 32'h01);
    pulse(5'h01, 1'b0);
    chk("irq set", 32'h1, {31'h0, irq});
    apb(1, 8'h08, 32'h01);
    chk("irq off", 32'h0, {31'h0, irq});
    apb(1, 8'h04, 32'h01);
    chk("irq back", 32'h1, {31'h0, irq});
    apb(0, 8'h14, 0);
    chk("status", 32'h1, rd);
    chk("irq cleared", 32'h0, {31'h0, irq});
    $display("test irq done");
  endtask
  initial begin
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    t_reset();
    t_time();
    t_idr();
    t_irq();
    end_sim();
  end
endmodule
